/* core/fmf_pkg.sv */
// Shared constants and types for the FM bit-cell byte framer
package fmf_pkg;

    // Core clock
    localparam int CLK_NS         = 100;
    // Bit cell and pulse timing
    localparam int CELL_NS        = 8000;
    localparam int CELL_CYC       = CELL_NS / CLK_NS;
    localparam int PULSE_NS       = 500;
    localparam int PULSE_CYC      = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    // Media revolution and index pulse
    localparam int REV_MS         = 200;
    localparam int REV_CYC        = REV_MS * 1000000 / CLK_NS;
    localparam int INDEX_NS       = 4000;
    localparam int INDEX_CYC      = (INDEX_NS + CLK_NS - 1) / CLK_NS;

    // Counter widths and sized timing points
    localparam int                TW         = 7;
    localparam logic [TW-1:0]     CELL_LAST  = TW'(CELL_CYC - 1);
    localparam logic [TW-1:0]     CELL_HALF  = TW'(CELL_CYC / 2);
    localparam logic [TW-1:0]     WIN_OPEN   = TW'(CELL_CYC / 4);
    localparam logic [TW-1:0]     WIN_CLOSE  = TW'(3 * CELL_CYC / 4);
    localparam logic [TW-1:0]     MISS_CYC   = TW'(CELL_CYC + CELL_CYC / 4);
    localparam logic [TW-1:0]     MISS_RELD  = TW'(CELL_CYC / 4 + 1);
    localparam logic [3:0]        PULSE_LEN  = 4'(PULSE_CYC);

    // Byte structure
    localparam logic [2:0]        LAST_CELL  = 3'h7;
    localparam logic [5:0]        SYNC_CELLS = 6'h20;
    localparam logic [7:0]        SYNC_ZEROS = 8'h04;
    localparam logic [7:0]        CLK_ALL    = 8'hff;
    localparam logic [7:0]        GAP_FILL   = 8'hff;
    localparam logic [7:0]        ZERO_BYTE  = 8'h00;

    // Host request kinds
    typedef enum logic [1:0] {
        FMF_TX_DATA,
        FMF_TX_MARK,
        FMF_TX_GAP
    } fmf_tx_kind_e;

    // Track gap types
    typedef enum logic [1:0] {
        FMF_POST_INDEX_GAP,
        FMF_ID_TO_DATA_GAP,
        FMF_INTER_RECORD_GAP,
        FMF_PRE_INDEX_GAP
    } fmf_gap_e;

endpackage : fmf_pkg

/* core/fmf_link_if.sv */
// Serial link between controller and drive, all lines active low
`timescale 1ns/100ps
interface fmf_link_if;
    logic wr_gate_n;
    logic wr_data_n;
    logic rd_data_n;
    logic index_n;
    logic wr_prot_n;

    modport drive (
        input  wr_gate_n,
        input  wr_data_n,
        output rd_data_n,
        output index_n,
        output wr_prot_n
    );

    modport ctrl (
        output wr_gate_n,
        output wr_data_n,
        input  rd_data_n,
        input  index_n,
        input  wr_prot_n
    );
endinterface : fmf_link_if

/* core/fmf_drive_end.sv */
// Drive end: index generator, write head current, raw read pulses
`timescale 1ns/100ps
module fmf_drive_end #(
    parameter int REV_CYC = fmf_pkg::REV_CYC
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    // Link to controller
    fmf_link_if.drive link,
    // Head and media side
    input  wire logic head_pulse_i,
    input  wire logic wr_protect_i,
    output logic      head_cur_o,
    output logic      flux_wr_o
);

    logic [20:0] rev_cnt;
    logic [5:0]  idx_cnt;
    logic [1:0]  hp_sync;
    logic [1:0]  wp_sync;
    logic        hp_q;
    logic        wd_q;
    logic [3:0]  rd_cnt;
    logic        wr_fall;

    // Revolution timer; one index pulse per turn
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rev_cnt <= 21'h0;
        end else if (rev_cnt == 21'(REV_CYC - 1)) begin
            rev_cnt <= 21'h0;
        end else begin
            rev_cnt <= rev_cnt + 21'h1;
        end
    end

    // Index hole sense, low for a fixed width at track start
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idx_cnt      <= 6'h0;
            link.index_n <= 1'b1;
        end else begin
            if (rev_cnt == 21'h0) begin
                idx_cnt <= 6'(fmf_pkg::INDEX_CYC);
            end else if (idx_cnt != 6'h0) begin
                idx_cnt <= idx_cnt - 6'h1;
            end
            link.index_n <= !(rev_cnt == 21'h0 || idx_cnt > 6'h1);
        end
    end

    // Head pulse and protect tab arrive asynchronously
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hp_sync <= 2'h0;
            wp_sync <= 2'h0;
            hp_q    <= 1'b0;
        end else begin
            hp_sync <= {hp_sync[0], head_pulse_i};
            wp_sync <= {wp_sync[0], wr_protect_i};
            hp_q    <= hp_sync[1];
        end
    end

    // Raw read data: clock and data pulses together, muted while writing
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_cnt         <= 4'h0;
            link.rd_data_n <= 1'b1;
            link.wr_prot_n <= 1'b1;
        end else begin
            if (hp_sync[1] && !hp_q && link.wr_gate_n) begin
                rd_cnt <= fmf_pkg::PULSE_LEN;
            end else if (rd_cnt != 4'h0) begin
                rd_cnt <= rd_cnt - 4'h1;
            end
            link.rd_data_n <= !(rd_cnt != 4'h0);
            link.wr_prot_n <= !wp_sync[1];
        end
    end

    // Write data falling edge reverses head current
    assign wr_fall = wd_q && !link.wr_data_n && !link.wr_gate_n && !wp_sync[1];

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wd_q       <= 1'b1;
            head_cur_o <= 1'b0;
            flux_wr_o  <= 1'b0;
        end else begin
            wd_q      <= link.wr_data_n;
            flux_wr_o <= wr_fall;
            if (wr_fall) begin
                head_cur_o <= !head_cur_o;
            end
        end
    end

endmodule : fmf_drive_end

/* core/fmf_ctrl_end.sv */
// Controller end: FM encoder, track formatter, data separator, byte aligner
//
// How it works
// - Every cell pairs a clock bit with data
// - Cell spans clock edge to next clock
// - Eight consecutive cells make one byte
// - Cell 0 holds MSB, cell 7 LSB
// - Write shifts cell 0 first, 7 last
// - Multi-byte writes go most significant first
// - Read assembles cell 0 first, MSB byte first
// - Track starts at index; identifiers precede records
// - Gap bytes separate every pair of fields
// - Gaps end in four zero bytes, except pre-index
// - Four gap types: index, id, data, pre-index
// - Drive pulses index once per revolution
// - Drive flips head current per falling edge
// - Marks omit some clock bits
`timescale 1ns/100ps
module fmf_ctrl_end (
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  arst_n_i,
    // Link to drive
    fmf_link_if.ctrl                   link,
    // Track control
    input  wire logic                  start_track_i,
    input  wire logic                  write_stop_i,
    output logic                       busy_o,
    output logic                       index_o,
    // Write byte stream
    input  wire logic                  tx_valid_i,
    input  wire fmf_pkg::fmf_tx_kind_e tx_kind_i,
    input  wire logic [7:0]            tx_data_i,
    input  wire logic [7:0]            tx_clk_i,
    input  wire fmf_pkg::fmf_gap_e     tx_gap_i,
    input  wire logic [7:0]            tx_len_i,
    output logic                       tx_ready_o,
    output logic                       underrun_o,
    // Read byte stream
    input  wire logic                  rd_en_i,
    input  wire logic                  field_end_i,
    output logic                       rx_valid_o,
    output logic [7:0]                 rx_data_o,
    output logic                       rx_mark_o,
    output logic                       rx_aligned_o
);

    typedef enum logic [1:0] {W_IDLE, W_WAIT_INDEX, W_SEND} fmf_wr_state_e;

    fmf_wr_state_e             state;
    logic                      idx_q;
    logic                      idx_fall;
    logic [fmf_pkg::TW-1:0]    cell_cnt;
    logic [2:0]                bit_idx;
    logic                      byte_end;
    logic                      need_byte;
    logic [7:0]                dt_sh;
    logic [7:0]                ck_sh;
    logic [3:0]                pw_cnt;
    logic                      gap_on;
    fmf_pkg::fmf_gap_e         gap_type;
    logic [7:0]                gap_left;
    logic                      gap_more;
    logic [7:0]                next_dt;
    logic [7:0]                next_ck;
    logic                      take_tx;
    logic                      rd_q;
    logic                      rd_fall;
    logic                      locked;
    logic [fmf_pkg::TW-1:0]    rtimer;
    logic                      cell_dat;
    logic                      prev_ck;
    logic                      is_clk;
    logic                      timeout;
    logic                      cell_ev;
    logic [7:0]                dsr;
    logic [7:0]                csr;
    logic [7:0]                next_dsr;
    logic [7:0]                next_csr;
    logic [5:0]                zrun;
    logic [2:0]                acnt;

    // Gap content: fill, then the closing zero bytes for the separator
    function automatic logic [7:0] gap_byte(input fmf_pkg::fmf_gap_e typ,
                                            input logic [7:0] left);
        if (typ != fmf_pkg::FMF_PRE_INDEX_GAP && left <= fmf_pkg::SYNC_ZEROS) begin
            gap_byte = fmf_pkg::ZERO_BYTE;
        end else begin
            gap_byte = fmf_pkg::GAP_FILL;
        end
    endfunction : gap_byte

    // Index edge, the link is on this clock already
    assign idx_fall = idx_q && !link.index_n;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idx_q   <= 1'b1;
            index_o <= 1'b0;
        end else begin
            idx_q   <= link.index_n;
            index_o <= idx_fall;
        end
    end

    // Write sequencing; a pre-index gap runs until the next index
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= W_IDLE;
        end else begin
            case (state)
                W_IDLE: begin
                    if (start_track_i) begin
                        state <= W_WAIT_INDEX;
                    end
                end
                W_WAIT_INDEX: begin
                    if (idx_fall) begin
                        state <= W_SEND;
                    end
                end
                W_SEND: begin
                    if ((write_stop_i && byte_end) || (idx_fall && gap_on
                            && gap_type == fmf_pkg::FMF_PRE_INDEX_GAP)) begin
                        state <= W_IDLE;
                    end
                end
                default: state <= W_IDLE;
            endcase
        end
    end

    assign busy_o    = state != W_IDLE;
    assign byte_end  = cell_cnt == fmf_pkg::CELL_LAST && bit_idx == fmf_pkg::LAST_CELL;
    assign need_byte = (state == W_WAIT_INDEX && idx_fall) || (state == W_SEND && byte_end);
    assign gap_more  = gap_on && (gap_type == fmf_pkg::FMF_PRE_INDEX_GAP || gap_left != 8'h0);
    assign take_tx   = need_byte && !gap_more && tx_valid_i;
    assign tx_ready_o = need_byte && !gap_more;

    // Byte source: running gap, host byte, or fill on underrun
    always_comb begin
        next_ck = fmf_pkg::CLK_ALL;
        next_dt = fmf_pkg::GAP_FILL;
        if (gap_more) begin
            next_dt = gap_byte(gap_type, gap_left);
        end else if (tx_valid_i) begin
            case (tx_kind_i)
                fmf_pkg::FMF_TX_MARK: begin
                    next_dt = tx_data_i;
                    next_ck = tx_clk_i;
                end
                fmf_pkg::FMF_TX_GAP: next_dt = gap_byte(tx_gap_i, tx_len_i);
                default: next_dt = tx_data_i;
            endcase
        end
    end

    // Gap bookkeeping, one count per byte sent
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gap_on   <= 1'b0;
            gap_type <= fmf_pkg::FMF_POST_INDEX_GAP;
            gap_left <= 8'h0;
        end else if (state == W_IDLE) begin
            gap_on <= 1'b0;
        end else if (need_byte) begin
            if (gap_more) begin
                gap_left <= gap_left - 8'h1;
            end else if (take_tx && tx_kind_i == fmf_pkg::FMF_TX_GAP) begin
                gap_on   <= 1'b1;
                gap_type <= tx_gap_i;
                gap_left <= (tx_len_i == 8'h0) ? 8'h0 : tx_len_i - 8'h1;
            end else begin
                gap_on <= 1'b0;
            end
        end
    end

    // Cell timer and MSB-first shifters
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cell_cnt   <= '0;
            bit_idx    <= 3'h0;
            dt_sh      <= 8'h0;
            ck_sh      <= 8'h0;
            underrun_o <= 1'b0;
        end else begin
            underrun_o <= need_byte && !gap_more && !tx_valid_i;
            if (need_byte) begin
                cell_cnt <= '0;
                bit_idx  <= 3'h0;
                dt_sh    <= next_dt;
                ck_sh    <= next_ck;
            end else if (state == W_SEND) begin
                if (cell_cnt == fmf_pkg::CELL_LAST) begin
                    cell_cnt <= '0;
                    bit_idx  <= bit_idx + 3'h1;
                    dt_sh    <= {dt_sh[6:0], 1'b0};
                    ck_sh    <= {ck_sh[6:0], 1'b0};
                end else begin
                    cell_cnt <= cell_cnt + 1'b1;
                end
            end
        end
    end

    // FM pulses: clock at cell start, data at mid-cell when one
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pw_cnt         <= 4'h0;
            link.wr_data_n <= 1'b1;
            link.wr_gate_n <= 1'b1;
        end else begin
            if (state == W_SEND && ((cell_cnt == '0 && ck_sh[7])
                    || (cell_cnt == fmf_pkg::CELL_HALF && dt_sh[7]))) begin
                pw_cnt <= fmf_pkg::PULSE_LEN;
            end else if (pw_cnt != 4'h0) begin
                pw_cnt <= pw_cnt - 4'h1;
            end
            link.wr_data_n <= !(pw_cnt != 4'h0);
            link.wr_gate_n <= !(state == W_SEND);
        end
    end

    // Data separator: pulses in the mid window are data, others clock
    assign rd_fall = rd_q && !link.rd_data_n;
    assign is_clk  = rd_fall && (!locked || rtimer < fmf_pkg::WIN_OPEN
                                 || rtimer >= fmf_pkg::WIN_CLOSE);
    assign timeout = locked && !rd_fall && rtimer == fmf_pkg::MISS_CYC;
    assign cell_ev = locked && (is_clk || timeout);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_q     <= 1'b1;
            locked   <= 1'b0;
            rtimer   <= '0;
            cell_dat <= 1'b0;
            prev_ck  <= 1'b0;
        end else begin
            rd_q <= link.rd_data_n;
            if (!rd_en_i) begin
                locked   <= 1'b0;
                rtimer   <= '0;
                cell_dat <= 1'b0;
            end else if (is_clk) begin
                locked   <= 1'b1;
                rtimer   <= fmf_pkg::TW'(1);
                cell_dat <= 1'b0;
                prev_ck  <= 1'b1;
            end else if (timeout) begin
                rtimer   <= fmf_pkg::MISS_RELD;
                cell_dat <= 1'b0;
                prev_ck  <= 1'b0;
            end else begin
                if (rd_fall) begin
                    cell_dat <= 1'b1;
                end
                rtimer <= rtimer + 1'b1;
            end
        end
    end

    // Finished cell enters at the low end; cell 0 ends up in the MSB
    assign next_dsr = {dsr[6:0], cell_dat};
    assign next_csr = {csr[6:0], prev_ck};

    // Byte alignment and delivery
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dsr          <= 8'h0;
            csr          <= 8'h0;
            zrun         <= 6'h0;
            acnt         <= 3'h0;
            rx_aligned_o <= 1'b0;
            rx_valid_o   <= 1'b0;
            rx_data_o    <= 8'h0;
            rx_mark_o    <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            if (!rd_en_i || field_end_i) begin
                rx_aligned_o <= 1'b0;
                zrun         <= 6'h0;
            end else if (cell_ev) begin
                dsr <= next_dsr;
                csr <= next_csr;
                // Cell leaving the window feeds the zero-run count
                if (!dsr[7] && csr[7]) begin
                    zrun <= (zrun == fmf_pkg::SYNC_CELLS) ? zrun : zrun + 6'h1;
                end else begin
                    zrun <= 6'h0;
                end
                if (!rx_aligned_o) begin
                    if (zrun == fmf_pkg::SYNC_CELLS && next_csr != fmf_pkg::CLK_ALL
                            && next_dsr[7]) begin
                        rx_aligned_o <= 1'b1;
                        acnt         <= 3'h0;
                        rx_valid_o   <= 1'b1;
                        rx_data_o    <= next_dsr;
                        rx_mark_o    <= 1'b1;
                    end
                end else begin
                    acnt <= acnt + 3'h1;
                    if (acnt == fmf_pkg::LAST_CELL) begin
                        rx_valid_o <= 1'b1;
                        rx_data_o  <= next_dsr;
                        rx_mark_o  <= next_csr != fmf_pkg::CLK_ALL;
                    end
                end
            end
        end
    end

endmodule : fmf_ctrl_end

/* verification/fmf_link_checker.sv */
// Checker on the serial link between controller and drive ends
`timescale 1ns/100ps
module fmf_link_checker #(
    parameter int REV_CYC = 2000
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    // Link lines
    input  wire logic wr_gate_n,
    input  wire logic wr_data_n,
    input  wire logic index_n,
    input  wire logic wr_prot_n,
    // End outputs
    input  wire logic head_cur_o,
    input  wire logic flux_wr_o,
    input  wire logic rx_valid_o,
    input  wire logic rx_mark_o,
    input  wire logic rx_aligned_o
);
    default clocking chk_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    logic [7:0]  idx_low;
    logic [31:0] idx_gap;
    logic        idx_seen;
    logic [15:0] rx_gap;

    // Width of the current index pulse
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idx_low <= 8'h00;
        end else begin
            idx_low <= index_n ? 8'h00 : idx_low + 8'h01;
        end
    end

    // Cycles since the last index edge; first edge has no reference
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idx_gap  <= 32'h0;
            idx_seen <= 1'b0;
        end else begin
            idx_gap  <= $fell(index_n) ? 32'h1 : idx_gap + 32'h1;
            idx_seen <= idx_seen | $fell(index_n);
        end
    end

    // Cycles since the last delivered byte, saturating so idle never wraps
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_gap <= 16'hffff;
        end else begin
            rx_gap <= rx_valid_o ? 16'h0001 : rx_gap + {15'h0, rx_gap != 16'hffff};
        end
    end

    a_idx_width: assert property (
        $rose(index_n) |-> idx_low == 8'(fmf_pkg::INDEX_CYC))
        else $error("index pulse width wrong");
    a_idx_period: assert property (
        $fell(index_n) && idx_seen |-> idx_gap == 32'(REV_CYC))
        else $error("index period wrong");
    a_start_at_index: assert property (
        $fell(wr_gate_n) |-> !index_n)
        else $error("write began away from index");
    a_wr_pulse_len: assert property (
        $fell(wr_data_n) |-> !wr_data_n [*5] ##1 wr_data_n)
        else $error("write pulse width wrong");
    a_cell_pulses: assert property (
        $fell(wr_data_n) && !wr_gate_n |-> ##[40:80] ($fell(wr_data_n) || wr_gate_n))
        else $error("bit cell lost its pulses");
    a_flux_follows: assert property (
        $fell(wr_data_n) && !wr_gate_n && wr_prot_n |=> flux_wr_o)
        else $error("no flux pulse after write edge");
    a_head_flip: assert property (
        (head_cur_o != $past(head_cur_o)) == flux_wr_o)
        else $error("head current flip not tied to flux pulse");
    a_rx_locked: assert property (
        rx_valid_o |-> rx_aligned_o)
        else $error("byte delivered while unaligned");
    a_lock_on_mark: assert property (
        $rose(rx_aligned_o) |-> rx_valid_o && rx_mark_o)
        else $error("alignment without mark byte");
    a_rx_byte_gap: assert property (
        rx_valid_o |-> rx_gap >= 16'h0258)
        else $error("read bytes closer than eight cells");

    c_locked: cover property ($rose(rx_aligned_o));
    c_flux: cover property (flux_wr_o);
    c_write: cover property ($fell(wr_gate_n));
endmodule : fmf_link_checker

/* verification/fmf_bit_cell_byte_framer_tb_top.sv */
// Testbench: controller and drive ends joined over the serial link
`timescale 1ns/100ps
module fmf_bit_cell_byte_framer_tb_top;
    localparam int REV   = 20000;
    localparam int LIMIT = 70000;

    logic                  core_clk_i, arst_n_i, head_pulse_i, wr_protect_i;
    logic                  head_cur_o, flux_wr_o, start_track_i, write_stop_i;
    logic                  busy_o, index_o, tx_valid_i, tx_ready_o, underrun_o;
    fmf_pkg::fmf_tx_kind_e tx_kind_i;
    fmf_pkg::fmf_gap_e     tx_gap_i;
    logic [7:0]            tx_data_i, tx_clk_i, tx_len_i, rx_data_o, rnd, wclk, wdat;
    logic                  rd_en_i, field_end_i, rx_valid_o, rx_mark_o, rx_aligned_o;
    int                    failures, tests_run, wcnt, und_n;
    int                    cyc = 0;
    logic [15:0]           wr_q[$];
    logic [15:0]           exp_q[$];
    logic [15:0]           rd_q[$];

    fmf_link_if fmf_link_if_i ();
    fmf_drive_end #(.REV_CYC(REV)) fmf_drive_end_i (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .link(fmf_link_if_i),
        .head_pulse_i(head_pulse_i), .wr_protect_i(wr_protect_i),
        .head_cur_o(head_cur_o), .flux_wr_o(flux_wr_o));
    fmf_ctrl_end fmf_ctrl_end_i (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .link(fmf_link_if_i),
        .start_track_i(start_track_i), .write_stop_i(write_stop_i), .busy_o(busy_o),
        .index_o(index_o), .tx_valid_i(tx_valid_i), .tx_kind_i(tx_kind_i),
        .tx_data_i(tx_data_i), .tx_clk_i(tx_clk_i), .tx_gap_i(tx_gap_i), .tx_len_i(tx_len_i),
        .tx_ready_o(tx_ready_o), .underrun_o(underrun_o), .rd_en_i(rd_en_i),
        .field_end_i(field_end_i), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
        .rx_mark_o(rx_mark_o), .rx_aligned_o(rx_aligned_o));
    fmf_link_checker #(.REV_CYC(REV)) fmf_link_checker_i (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .wr_gate_n(fmf_link_if_i.wr_gate_n), .wr_data_n(fmf_link_if_i.wr_data_n),
        .index_n(fmf_link_if_i.index_n), .wr_prot_n(fmf_link_if_i.wr_prot_n),
        .head_cur_o(head_cur_o), .flux_wr_o(flux_wr_o), .rx_valid_o(rx_valid_o),
        .rx_mark_o(rx_mark_o), .rx_aligned_o(rx_aligned_o));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // Gap byte i of n: fill first, the last four are zero
    function automatic logic [15:0] gap_byte(input int i, input int n);
        return {8'hff, (i < n - 4) ? 8'hff : 8'h00};
    endfunction : gap_byte

    task automatic cmp_byte(input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp_byte

    task automatic cmp_bit(input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp_bit

    // Hold the request until a ready cycle has passed its edge
    task automatic put(input fmf_pkg::fmf_tx_kind_e k, input logic [7:0] d,
                       input logic [7:0] c, input fmf_pkg::fmf_gap_e g, input logic [7:0] n);
        @(negedge core_clk_i);
        tx_kind_i = k;
        tx_data_i = d;
        tx_clk_i = c;
        tx_gap_i = g;
        tx_len_i = n;
        tx_valid_i = 1'b1;
        while (tx_ready_o !== 1'b1) @(negedge core_clk_i);
        @(negedge core_clk_i);
        tx_valid_i = 1'b0;
    endtask : put

    // Media stands in: clock pulse at cell start, data pulse mid-cell
    task automatic fm_byte(input logic [7:0] c, input logic [7:0] d);
        for (int i = 0; i < 640; i++) begin
            @(negedge core_clk_i);
            head_pulse_i = (c[7 - i / 80] && i % 80 < 3) ||
                           (d[7 - i / 80] && i % 80 >= 40 && i % 80 < 43);
        end
    endtask : fm_byte

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // Hang guard
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            print_verdict();
        end
    end

    // Decode write line into {clock bits, data bits}; windows tolerate small skew
    always @(negedge core_clk_i) begin
        if (underrun_o === 1'b1) und_n++;
        if (rx_valid_o === 1'b1) rd_q.push_back({7'h00, rx_mark_o, rx_data_o});
        if (fmf_link_if_i.wr_gate_n !== 1'b0) begin
            wcnt = 0;
        end else begin
            if (wcnt % 640 == 0) {wclk, wdat} = 16'h0000;
            if (fmf_link_if_i.wr_data_n === 1'b0 && wcnt % 80 < 20) wclk[7 - wcnt / 80 % 8] = 1'b1;
            if (fmf_link_if_i.wr_data_n === 1'b0 && wcnt % 80 >= 30 && wcnt % 80 < 60)
                wdat[7 - wcnt / 80 % 8] = 1'b1;
            if (wcnt % 640 == 639) wr_q.push_back({wclk, wdat});
            wcnt++;
        end
    end

    initial begin
        failures = 0;
        tests_run = 0;
        und_n = 0;
        wcnt = 0;
        rnd = 8'h1b;
        arst_n_i = 1'b0;
        head_pulse_i = 1'b0;
        wr_protect_i = 1'b0;
        start_track_i = 1'b0;
        write_stop_i = 1'b0;
        tx_valid_i = 1'b0;
        tx_kind_i = fmf_pkg::FMF_TX_DATA;
        tx_gap_i = fmf_pkg::FMF_POST_INDEX_GAP;
        {tx_data_i, tx_clk_i, tx_len_i} = 24'h000000;
        rd_en_i = 1'b0;
        field_end_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        @(negedge core_clk_i);
        start_track_i = 1'b1;
        @(negedge core_clk_i);
        start_track_i = 1'b0;
        // Word high byte first, then one more; clock pattern must be ignored for data
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            put(fmf_pkg::FMF_TX_DATA, rnd, ~rnd, fmf_pkg::FMF_POST_INDEX_GAP, 8'h00);
            exp_q.push_back({8'hff, rnd});
        end
        put(fmf_pkg::FMF_TX_MARK, 8'hfe, 8'hc7, fmf_pkg::FMF_POST_INDEX_GAP, 8'h00);
        exp_q.push_back(16'hc7fe);
        for (int g = 0; g < 3; g++) begin
            put(fmf_pkg::FMF_TX_GAP, 8'h00, 8'h00, fmf_pkg::fmf_gap_e'(2'(g)), 8'(4 + g));
            for (int j = 0; j < 4 + g; j++) exp_q.push_back(gap_byte(j, 4 + g));
        end
        while (und_n == 0) @(negedge core_clk_i); // Missed slot: fill, then pre-index gap
        exp_q.push_back(16'hffff);
        put(fmf_pkg::FMF_TX_GAP, 8'h00, 8'h00, fmf_pkg::FMF_PRE_INDEX_GAP, 8'h01);
        cmp_byte(16'h0001, 16'(und_n));
        cmp_bit(1'b1, busy_o);
        while (busy_o !== 1'b0) @(negedge core_clk_i);
        foreach (exp_q[i]) cmp_byte(exp_q[i], wr_q[i]);
        cmp_bit(1'b1, wr_q.size() > exp_q.size());
        for (int i = exp_q.size(); i < wr_q.size(); i++) cmp_byte(16'hffff, wr_q[i]);
        $display("test track_write done");
        // Read: sync zeros, mark, three random bytes, trailing zero
        exp_q.delete();
        exp_q.push_back(16'h01fe);
        rd_en_i = 1'b1;
        repeat (5) fm_byte(8'hff, 8'h00);
        fm_byte(8'hc7, 8'hfe);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            exp_q.push_back({8'h00, rnd});
            fm_byte(8'hff, rnd);
        end
        fm_byte(8'hff, 8'h00);
        cmp_bit(1'b1, rx_aligned_o);
        field_end_i = 1'b1;
        @(negedge core_clk_i);
        field_end_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        cmp_bit(1'b0, rx_aligned_o);
        foreach (exp_q[i]) cmp_byte(exp_q[i], rd_q[i]);
        $display("test field_read done");
        print_verdict();
    end
endmodule : fmf_bit_cell_byte_framer_tb_top
